// ==== shared/fsr_regs.svh ====
// Register offsets, field positions and reset values of the fault status bank.
`ifndef FSR_REGS_SVH
`define FSR_REGS_SVH

`define FSR_CMD_CLEAR_FAULTS 8'h03
`define FSR_OFF_SUM_BYTE     8'h78
`define FSR_OFF_SUM_WORD     8'h79
`define FSR_OFF_VOLT         8'h7A
`define FSR_OFF_CURR         8'h7B
`define FSR_OFF_TEMP         8'h7D
`define FSR_OFF_COMM         8'h7E

`define FSR_BIT_OV           6
`define FSR_BIT_UV           5
`define FSR_BIT_OC           5
`define FSR_BIT_OT           6
`define FSR_BIT_UNSUPPORTED_COMMAND_FLAG_F      7
`define FSR_BIT_USDAT_F      6
`define FSR_BIT_PEC_F        5
`define FSR_BIT_GCOM_F       1
`define FSR_BIT_BUSY         7
`define FSR_BIT_TEMP_SUM     2
`define FSR_BIT_COMM_SUM     1
`define FSR_BIT_VOLT_SUM     15
`define FSR_BIT_CURR_SUM     14

`define FSR_RST_BYTE         8'h00
`define FSR_RST_WORD         16'h0000

`endif

// ==== shared/fsr_pkg.sv ====
// Types shared by the fault status bank.
package fsr_pkg;

  // Fault events from the monitor and the serial front end.
  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic ot;
    logic unsupported_command_flag;
    logic unsupported_data_flag;
    logic pec;
    logic gcom;
    logic busy;
  } fsr_evt_t;

  // Register access from the serial command decoder.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        clr_all;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } fsr_acc_t;

  typedef enum logic [1:0] {
    FSR_RD_IDLE = 2'b00,
    FSR_RD_HOLD = 2'b01
  } fsr_rd_state_t;

endpackage

// ==== design/fsr_flag.sv ====
// One latched write-one-to-clear status flag.
`timescale 1ns/1ps
`default_nettype none

module fsr_flag
(
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  // An event in the clearing cycle keeps the flag set.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end

endmodule

`default_nettype wire

// ==== design/fsr_sync.sv ====
// Two-stage synchroniser for a group of level inputs.
`timescale 1ns/1ps
`default_nettype none

module fsr_sync
#(
  parameter int W = 4
)
(
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  // A zero-width group has nothing to carry and is refused at elaboration.
  if (W < 1)
  begin : g_bad_width
    $error("fsr_sync: width must be at least one");
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      q_o     <= '0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// ==== design/fsr_status_bank.sv ====
// Latched fault status bank with hierarchical summary byte and word.
//
// Behaviour
// - Bus overvoltage sets and latches voltage status bit 6.
// - Writing one to bus overvoltage warning clears it.
// - Bus undervoltage sets and latches voltage status bit 5.
// - Writing one to bus undervoltage warning clears it.
// - Shunt overcurrent sets and latches current status bit 5.
// - Writing one to overcurrent warning clears it.
// - Over-temperature latches temperature bit 6; writing one clears it.
// - Unsupported command latches comm status bit 7.
// - Unsupported data form latches comm status bit 6.
// - Failed packet error check latches comm status bit 5.
// - Other bus errors latch comm status bit 1.
// - Each comm error flag holds until a one is written.
// - Busy latches summary byte bit 7; writing one clears it.
// - Over-temperature also latches summary byte bit 2.
// - Any comm error latches summary bit 1; writing one clears.
// - Summary flags clear independently of their source flags.
// - Either bus voltage warning latches word bit 15; one clears.
// - Summary word low byte mirrors the summary byte.
// - Overcurrent also latches word bit 14; writing one clears.
// - Clear-faults command returns every status register to zero.
// - A masked lower flag does not set its summary flag.
`timescale 1ns/1ps
`default_nettype none
`include "fsr_regs.svh"

module fsr_status_bank
  import fsr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire fsr_evt_t    async_evt_i,
  input  wire fsr_evt_t    comm_evt_i,
  input  wire fsr_evt_t    mask_i,
  input  wire fsr_acc_t    acc_i,
  output logic [15:0]      rdata_o,
  output logic             rvalid_o,
  output logic             unmapped_o
);

  //--------------------------------------------------------------
  // Event synchronisation
  //--------------------------------------------------------------

  logic [3:0] ana_sync;
  fsr_evt_t   evt;

  fsr_sync #(.W(4)) u_sync
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({async_evt_i.ov, async_evt_i.uv,
               async_evt_i.oc, async_evt_i.ot}),
    .q_o     (ana_sync)
  );

  always_comb
  begin
    evt    = comm_evt_i;
    evt.ov = ana_sync[3];
    evt.uv = ana_sync[2];
    evt.oc = ana_sync[1];
    evt.ot = ana_sync[0];
  end

  //--------------------------------------------------------------
  // Write decode
  //--------------------------------------------------------------

  function automatic logic wr1(input fsr_acc_t a, input logic [7:0] off,
                               input int bit_n);
    wr1 = a.wr && (a.addr == off) && a.wdata[bit_n];
  endfunction

  // Per-flag clear: a written one or the clear-faults command.
  logic c_ov, c_uv, c_oc, c_ot, c_us, c_ud, c_pe, c_gc;
  logic c_busy, c_tsum, c_csum, c_vsum, c_isum;

  always_comb
  begin
    c_ov   = acc_i.clr_all || wr1(acc_i, `FSR_OFF_VOLT, `FSR_BIT_OV);
    c_uv   = acc_i.clr_all || wr1(acc_i, `FSR_OFF_VOLT, `FSR_BIT_UV);
    c_oc   = acc_i.clr_all || wr1(acc_i, `FSR_OFF_CURR, `FSR_BIT_OC);
    c_ot   = acc_i.clr_all || wr1(acc_i, `FSR_OFF_TEMP, `FSR_BIT_OT);
    c_us   = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_COMM, `FSR_BIT_UNSUPPORTED_COMMAND_FLAG_F);
    c_ud   = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_COMM, `FSR_BIT_USDAT_F);
    c_pe   = acc_i.clr_all || wr1(acc_i, `FSR_OFF_COMM, `FSR_BIT_PEC_F);
    c_gc   = acc_i.clr_all || wr1(acc_i, `FSR_OFF_COMM, `FSR_BIT_GCOM_F);
    // Summary byte bits clear from either the byte or the word view; bits 15 and 14 clear only from the word view.
    c_busy = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_SUM_BYTE, `FSR_BIT_BUSY)
             || wr1(acc_i, `FSR_OFF_SUM_WORD, `FSR_BIT_BUSY);
    c_tsum = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_SUM_BYTE, `FSR_BIT_TEMP_SUM)
             || wr1(acc_i, `FSR_OFF_SUM_WORD, `FSR_BIT_TEMP_SUM);
    c_csum = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_SUM_BYTE, `FSR_BIT_COMM_SUM)
             || wr1(acc_i, `FSR_OFF_SUM_WORD, `FSR_BIT_COMM_SUM);
    c_vsum = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_SUM_WORD, `FSR_BIT_VOLT_SUM);
    c_isum = acc_i.clr_all
             || wr1(acc_i, `FSR_OFF_SUM_WORD, `FSR_BIT_CURR_SUM);
  end

  //--------------------------------------------------------------
  // Latched flags
  //--------------------------------------------------------------

  logic ov_ff, uv_ff, oc_ff, ot_ff, us_ff, ud_ff, pe_ff, gc_ff;
  logic busy_ff, tsum_ff, csum_ff, vsum_ff, isum_ff;
  logic s_csum, s_vsum;

  // Summary sources pass only when the lower event is unmasked.
  always_comb
  begin
    s_csum = (evt.unsupported_command_flag && !mask_i.unsupported_command_flag) || (evt.unsupported_data_flag && !mask_i.unsupported_data_flag)
             || (evt.pec && !mask_i.pec)
             || (evt.gcom && !mask_i.gcom);
    s_vsum = (evt.ov && !mask_i.ov) || (evt.uv && !mask_i.uv);
  end

  // The flag cell lets a set win over a clear.
  fsr_flag u_ov (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.ov),
                 .clr_i(c_ov), .flag_o(ov_ff));
  fsr_flag u_uv (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.uv),
                 .clr_i(c_uv), .flag_o(uv_ff));
  fsr_flag u_oc (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.oc),
                 .clr_i(c_oc), .flag_o(oc_ff));
  fsr_flag u_ot (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.ot),
                 .clr_i(c_ot), .flag_o(ot_ff));
  fsr_flag u_us (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.unsupported_command_flag),
                 .clr_i(c_us), .flag_o(us_ff));
  fsr_flag u_ud (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.unsupported_data_flag),
                 .clr_i(c_ud), .flag_o(ud_ff));
  fsr_flag u_pe (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.pec),
                 .clr_i(c_pe), .flag_o(pe_ff));
  fsr_flag u_gc (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.gcom),
                 .clr_i(c_gc), .flag_o(gc_ff));
  fsr_flag u_bz (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(evt.busy),
                 .clr_i(c_busy), .flag_o(busy_ff));
  fsr_flag u_ts (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
                 .set_i(evt.ot && !mask_i.ot),
                 .clr_i(c_tsum), .flag_o(tsum_ff));
  fsr_flag u_cs (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(s_csum),
                 .clr_i(c_csum), .flag_o(csum_ff));
  fsr_flag u_vs (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(s_vsum),
                 .clr_i(c_vsum), .flag_o(vsum_ff));
  fsr_flag u_is (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
                 .set_i(evt.oc && !mask_i.oc),
                 .clr_i(c_isum), .flag_o(isum_ff));

  //--------------------------------------------------------------
  // Register images and read port
  //--------------------------------------------------------------

  logic [7:0]  sum_byte;
  logic [15:0] nxt_rdata;
  logic        nxt_unmapped;

  always_comb
  begin
    sum_byte = `FSR_RST_BYTE;
    sum_byte[`FSR_BIT_BUSY]     = busy_ff;
    sum_byte[`FSR_BIT_TEMP_SUM] = tsum_ff;
    sum_byte[`FSR_BIT_COMM_SUM] = csum_ff;
    nxt_rdata    = `FSR_RST_WORD;
    nxt_unmapped = 1'b0;
    case (acc_i.addr)
      `FSR_OFF_SUM_BYTE: nxt_rdata[7:0] = sum_byte;
      `FSR_OFF_SUM_WORD:
      begin
        nxt_rdata[7:0]               = sum_byte;
        nxt_rdata[`FSR_BIT_VOLT_SUM] = vsum_ff;
        nxt_rdata[`FSR_BIT_CURR_SUM] = isum_ff;
      end
      `FSR_OFF_VOLT:
      begin
        nxt_rdata[`FSR_BIT_OV] = ov_ff;
        nxt_rdata[`FSR_BIT_UV] = uv_ff;
      end
      `FSR_OFF_CURR: nxt_rdata[`FSR_BIT_OC] = oc_ff;
      `FSR_OFF_TEMP: nxt_rdata[`FSR_BIT_OT] = ot_ff;
      `FSR_OFF_COMM:
      begin
        nxt_rdata[`FSR_BIT_UNSUPPORTED_COMMAND_FLAG_F] = us_ff;
        nxt_rdata[`FSR_BIT_USDAT_F] = ud_ff;
        nxt_rdata[`FSR_BIT_PEC_F]   = pe_ff;
        nxt_rdata[`FSR_BIT_GCOM_F]  = gc_ff;
      end
      default: nxt_unmapped = 1'b1;
    endcase
  end

  // Read data answers one cycle after the read strobe.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o    <= `FSR_RST_WORD;
      rvalid_o   <= 1'b0;
      unmapped_o <= 1'b0;
    end
    else
    begin
      rvalid_o   <= acc_i.rd;
      unmapped_o <= acc_i.rd && nxt_unmapped;
      if (acc_i.rd)
        rdata_o <= nxt_rdata;
    end
  end

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------

  property p_ov_set;
    @(posedge mclk_i) disable iff (!rst_n_i)
      evt.ov |=> ov_ff;
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("ov flag not set");

  property p_ov_clr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr1(acc_i, `FSR_OFF_VOLT, `FSR_BIT_OV) && !evt.ov) |=> !ov_ff;
  endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("ov not cleared");

  property p_uv_set;
    @(posedge mclk_i) disable iff (!rst_n_i)
      evt.uv |=> uv_ff;
  endproperty
  a_uv_set: assert property (p_uv_set) else $error("uv flag not set");

  property p_vsum_set;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_vsum |=> vsum_ff;
  endproperty
  a_vsum_set: assert property (p_vsum_set) else $error("vsum not set");

  property p_csum_set;
    @(posedge mclk_i) disable iff (!rst_n_i)
      s_csum |=> csum_ff;
  endproperty
  a_csum_set: assert property (p_csum_set) else $error("csum not set");

  property p_busy_clr;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr1(acc_i, `FSR_OFF_SUM_BYTE, `FSR_BIT_BUSY) && !evt.busy) |=> !busy_ff;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy kept");

  property p_oc_pair;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (evt.oc && !mask_i.oc) |=> oc_ff && isum_ff;
  endproperty
  a_oc_pair: assert property (p_oc_pair) else $error("oc pair");

  property p_ot_pair;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (evt.ot && !mask_i.ot) |=> ot_ff && tsum_ff;
  endproperty
  a_ot_pair: assert property (p_ot_pair) else $error("ot pair");

  property p_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (gc_ff && !c_gc) |=> gc_ff;
  endproperty
  a_hold: assert property (p_hold) else $error("comm flag dropped");

  property p_mask;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!csum_ff && !s_csum) |=> !csum_ff;
  endproperty
  a_mask: assert property (p_mask) else $error("summary set masked");

  property p_clear_all;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (acc_i.clr_all && evt == '0) |=> !ov_ff && !gc_ff && !busy_ff
                                       && !vsum_ff && !csum_ff;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear all");

  property p_set_wins;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (evt.pec && c_pe) |=> pe_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_word_low;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (acc_i.rd && acc_i.addr == `FSR_OFF_SUM_WORD)
        |=> rvalid_o && rdata_o[7:0] == $past(sum_byte)
            && rdata_o[13:8] == 6'h00;
  endproperty
  a_word_low: assert property (p_word_low) else $error("word low");

endmodule

`default_nettype wire

// ==== test/fsr_host_model.sv ====
// Host model that reads, writes and clears the fault status bank.
`timescale 1ns/1ps
`default_nettype none

module fsr_host_model
  import fsr_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        unmapped_i,
  output var  fsr_acc_t    acc_o
);
  initial acc_o = '0;

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // One request held for one edge; on release the strobes drop to zero and address and data show inverted values.
  task automatic req(input logic w, input logic r, input logic c,
                     input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    acc_o <= '{wr: w, rd: r, clr_all: c, addr: a, wdata: d};
    @(posedge mclk_i);
    acc_o <= '{wr: 1'b0, rd: 1'b0, clr_all: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] q,
                    output logic u);
    req(1'b0, 1'b1, 1'b0, a, 16'h0000);
    #1;
    q = rvalid_i ? rdata_i : 16'hXXXX;
    u = rvalid_i ? unmapped_i : 1'bX;
  endtask
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench of the fault status bank.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import fsr_pkg::*;
  logic        mclk;
  logic        rst_n;
  fsr_evt_t    aev;
  fsr_evt_t    cev;
  fsr_evt_t    msk;
  fsr_acc_t    acc;
  logic [15:0] rdata;
  logic        rvalid;
  logic        unm;
  int          err_total;
  int          n_checks;
  int          cyc;

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  fsr_status_bank dut (.mclk_i(mclk), .rst_n_i(rst_n), .async_evt_i(aev),
    .comm_evt_i(cev), .mask_i(msk), .acc_i(acc), .rdata_o(rdata),
    .rvalid_o(rvalid), .unmapped_o(unm));

  fsr_host_model host (.mclk_i(mclk), .rdata_i(rdata), .rvalid_i(rvalid),
    .unmapped_i(unm), .acc_o(acc));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic        u;
    host.rd(a, q, u);
    chk16(q, exp);
    chk1(u, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.req(1'b1, 1'b0, 1'b0, a, d);
  endtask

  // Async events cross a two-flop synchroniser, so they are held longer.
  task automatic fire(input fsr_evt_t e, input logic is_async);
    @(posedge mclk);
    if (is_async)
      aev <= e;
    else
      cev <= e;
    repeat (is_async ? 3 : 1) @(posedge mclk);
    aev <= '0;
    cev <= '0;
    repeat (4) @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic run_evt(input fsr_evt_t e, input logic is_async,
                         input logic [7:0] a, input logic [15:0] s,
                         input logic [7:0] sa, input logic [15:0] se);
    fire(e, is_async);
    rdchk(a, s);
    wr(a, 16'h0000);
    rdchk(a, s);
    rdchk(sa, se);
    wr(a, s);
    rdchk(a, 16'h0000);
    rdchk(sa, se);
    wr(sa, se);
    rdchk(sa, 16'h0000);
  endtask

  task automatic test_reset_values();
    logic [7:0] offs [6] = '{8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7D, 8'h7E};
    foreach (offs[i]) rdchk(offs[i], 16'h0000);
  endtask

  task automatic test_busy_and_unmapped();
    logic [15:0] q;
    logic        u;
    fire(fsr_evt_t'(9'h001), 1'b0);
    rdchk(8'h79, 16'h0080);
    wr(8'h78, 16'h0080);
    rdchk(8'h78, 16'h0000);
    wr(8'h7A, 16'hFFFF);
    rdchk(8'h7A, 16'h0000);
    host.rd(8'h7C, q, u);
    chk1(u, 1'b1);
  endtask

  task automatic test_mask();
    @(posedge mclk);
    msk <= fsr_evt_t'(9'h002);
    fire(fsr_evt_t'(9'h002), 1'b0);
    rdchk(8'h7E, 16'h0002);
    rdchk(8'h78, 16'h0000);
    wr(8'h7E, 16'h0002);
    @(posedge mclk);
    msk <= '0;
  endtask

  task automatic test_set_beats_clear();
    fork
      wr(8'h7E, 16'h0020);
      begin
        @(posedge mclk);
        cev <= fsr_evt_t'(9'h004);
        @(posedge mclk);
        cev <= '0;
      end
    join
    rdchk(8'h7E, 16'h0020);
    wr(8'h7E, 16'h0020);
    wr(8'h78, 16'h0002);
  endtask

  task automatic test_clear_faults();
    fire(fsr_evt_t'(9'h140), 1'b1);
    fire(fsr_evt_t'(9'h011), 1'b0);
    rdchk(8'h79, 16'hC082);
    host.req(1'b0, 1'b0, 1'b1, 8'h03, 16'h0000);
    test_reset_values();
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst_n = 1'b0;
    aev = '0;
    cev = '0;
    msk = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    test_reset_values();
    run_evt(fsr_evt_t'(9'h100), 1'b1, 8'h7A, 16'h0040,
            8'h79, 16'h8000);
    run_evt(fsr_evt_t'(9'h080), 1'b1, 8'h7A, 16'h0020,
            8'h79, 16'h8000);
    run_evt(fsr_evt_t'(9'h040), 1'b1, 8'h7B, 16'h0020,
            8'h79, 16'h4000);
    run_evt(fsr_evt_t'(9'h020), 1'b1, 8'h7D, 16'h0040,
            8'h79, 16'h0004);
    run_evt(fsr_evt_t'(9'h010), 1'b0, 8'h7E, 16'h0080,
            8'h78, 16'h0002);
    run_evt(fsr_evt_t'(9'h008), 1'b0, 8'h7E, 16'h0040,
            8'h78, 16'h0002);
    run_evt(fsr_evt_t'(9'h004), 1'b0, 8'h7E, 16'h0020,
            8'h78, 16'h0002);
    run_evt(fsr_evt_t'(9'h002), 1'b0, 8'h7E, 16'h0002,
            8'h78, 16'h0002);
    test_busy_and_unmapped();
    test_mask();
    test_set_beats_clear();
    test_clear_faults();
    tally_and_finish();
  end
endmodule

`default_nettype wire
